// >>> hdl/jie_core.sv
// Execute logic for the absolute jump and the register increment
`timescale 1ns/100ps

// What this block does
// RULE1: Jump is two words: EF plus low literal, then F plus high literal.
// RULE2: Jump loads the 20-bit literal into PC bits 20:1, bit 0 zero.
// RULE3: Jump takes two cycles; low literal at Q2, high and PC at Q4.
// RULE4: Jump reaches all of program space and changes no flag.
// RULE5: Increment is one word: 001010, dest bit, access bit, address.
// RULE6: Increment adds one and sets carry, digit carry, N, OV and Z.
// RULE7: Dest bit 0 writes working register, 1 writes the file register.
// RULE8: Access bit 0 uses access bank, 1 uses the bank pointer.
// RULE9: Extended set, access bit 0 and address up to 5F use indexing.
// RULE10: Increment decodes Q1, reads Q2, computes Q3, writes Q4.
// RULE11: Second jump cycle does nothing and drops the prefetched word.
module jie_core
    import jie_pkg::*;
(
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [PC_W-1:0] PROG_ADDR_O,
    input wire logic [15:0] PROG_DATA_I,
    output logic [DADDR_W-1:0] DMEM_ADDR_O,
    input wire logic [7:0] DMEM_RDATA_I,
    output logic [7:0] DMEM_WDATA_O,
    output logic DMEM_WE_O,
    output logic [3:0] PHASE_O
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [3:0] q;
    logic [1:0] ctrl_q, ctrl_d;
    logic [3:0] bank_q, bank_d;
    logic [7:0] wreg_q, wreg_d;
    jie_flags_type flags_q, flags_d;
    logic [DADDR_W-1:0] base_q, base_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [15:0] ir_q, ir_d;
    logic [7:0] lit_lo_q, lit_lo_d;
    logic [DADDR_W-1:0] addr_q, addr_d;
    logic [7:0] opnd_q, opnd_d;
    jie_state_type state_q, state_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [7:0] alu_res;
    jie_flags_type alu_flags;
    logic run, ext_en, exec, is_jump, is_inc, dest_f, acc_bpr;
    logic [7:0] fadr;
    logic wr_acc;

    assign run = ctrl_q[CTRL_RUN_BIT];
    assign ext_en = ctrl_q[CTRL_EXT_BIT];
    assign exec = (state_q == ST_EXEC);
    assign is_jump = (ir_q[15:8] == JUMP_OP_HI); // RULE1
    assign is_inc = (ir_q[15:INC_TOP_LSB] == INC_OP_TOP); // RULE5
    assign dest_f = ir_q[DEST_BIT];
    assign acc_bpr = ir_q[ACC_BIT];
    assign fadr = ir_q[7:0];

    // ************************************************************
    // Phase sequencer and incrementer
    // ************************************************************
    jie_phase_gen u_phase (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .en_i(run),
        .q_o(q)
    );

    jie_inc_alu u_alu (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .en_i(q[2] && exec && is_inc), // RULE10
        .val_i(opnd_q),
        .res_o(alu_res),
        .flags_o(alu_flags)
    );

    // ************************************************************
    // Wishbone slave answer
    // ************************************************************
    assign wr_acc = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q;

    always_comb begin
        ack_d = WB_CYC_I && WB_STB_I && !ack_q;
        rdat_d = 32'h0000_0000;
        unique case (WB_ADR_I)
            CTRL_OFS: rdat_d[1:0] = ctrl_q;
            BANK_OFS: rdat_d[3:0] = bank_q;
            WREG_OFS: rdat_d[7:0] = wreg_q;
            FLAGS_OFS: rdat_d[4:0] = flags_q;
            PC_OFS: rdat_d[PC_W-1:0] = pc_q;
            BASE_OFS: rdat_d[DADDR_W-1:0] = base_q;
            default: rdat_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdat_q;

    // ************************************************************
    // Execute state
    // ************************************************************
    always_comb begin
        ctrl_d = ctrl_q;
        bank_d = bank_q;
        wreg_d = wreg_q;
        flags_d = flags_q;
        base_d = base_q;
        pc_d = pc_q;
        ir_d = ir_q;
        lit_lo_d = lit_lo_q;
        addr_d = addr_q;
        opnd_d = opnd_q;
        state_d = state_q;
        // Software writes first; the core's own Q4 update wins below
        if (wr_acc && WB_SEL_I[0]) begin
            unique case (WB_ADR_I)
                CTRL_OFS: ctrl_d = WB_DAT_I[1:0];
                BANK_OFS: bank_d = WB_DAT_I[3:0];
                WREG_OFS: wreg_d = WB_DAT_I[7:0];
                FLAGS_OFS: flags_d = WB_DAT_I[4:0];
                BASE_OFS: base_d[7:0] = WB_DAT_I[7:0];
                default: ;
            endcase
        end
        if (wr_acc && WB_SEL_I[1] && WB_ADR_I == BASE_OFS) begin
            base_d[DADDR_W-1:8] = WB_DAT_I[DADDR_W-1:8];
        end
        // Q1: resolve the data address of an increment
        if (q[0] && exec && is_inc) begin
            if (acc_bpr) begin
                addr_d = {bank_q, fadr}; // RULE8
            end else if (ext_en && fadr <= INDEX_LIMIT) begin
                addr_d = base_q + {4'h0, fadr}; // RULE9
            end else if (fadr < ACC_SPLIT) begin
                addr_d = {ACC_LO_PAGE, fadr}; // RULE8
            end else begin
                addr_d = {ACC_HI_PAGE, fadr};
            end
        end
        // Q2: jump takes its low literal, increment reads memory
        if (q[1] && exec) begin
            if (is_jump) begin
                lit_lo_d = fadr; // RULE3
            end
            if (is_inc) begin
                opnd_d = DMEM_RDATA_I; // RULE10
            end
        end
        // Q4: write back, fetch, and redirect on a jump
        if (q[3]) begin
            if (exec && is_jump) begin
                pc_d = {PROG_DATA_I[11:0], lit_lo_q, 1'b0}; // RULE2 RULE4
                ir_d = NOP_WORD; // RULE11
                state_d = ST_FLUSH; // RULE3
            end else begin
                ir_d = PROG_DATA_I;
                pc_d = pc_q + PC_STEP;
                state_d = ST_EXEC;
            end
            if (exec && is_inc) begin
                flags_d = alu_flags; // RULE6
                if (!dest_f) begin
                    wreg_d = alu_res; // RULE7
                end
            end
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_q <= CTRL_RST;
            bank_q <= BANK_RST;
            wreg_q <= WREG_RST;
            flags_q <= FLAGS_RST;
            base_q <= BASE_RST;
            pc_q <= PC_RST;
            ir_q <= NOP_WORD;
            lit_lo_q <= 8'h00;
            addr_q <= 12'h000;
            opnd_q <= 8'h00;
            state_q <= ST_EXEC;
        end else begin
            ctrl_q <= ctrl_d;
            bank_q <= bank_d;
            wreg_q <= wreg_d;
            flags_q <= flags_d;
            base_q <= base_d;
            pc_q <= pc_d;
            ir_q <= ir_d;
            lit_lo_q <= lit_lo_d;
            addr_q <= addr_d;
            opnd_q <= opnd_d;
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign PROG_ADDR_O = pc_q;
    assign DMEM_ADDR_O = addr_q;
    assign DMEM_WDATA_O = alu_res;
    assign DMEM_WE_O = q[3] && exec && is_inc && dest_f; // RULE7 RULE10
    assign PHASE_O = q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    jump_target_a: assert property ( // RULE2
        q[3] && exec && is_jump |=>
        pc_q == {$past(PROG_DATA_I[11:0]), $past(lit_lo_q), 1'b0})
        else $error("jump target not loaded into pc");

    pc_align_a: assert property (pc_q[0] == 1'b0) // RULE2
        else $error("pc bit 0 set");

    jump_flush_a: assert property ( // RULE3
        q[3] && exec && is_jump && run |=>
        state_q == ST_FLUSH && ir_q == NOP_WORD)
        else $error("jump did not enter its second cycle");

    jump_literal_a: assert property ( // RULE3
        q[1] && exec && is_jump |=> lit_lo_q == $past(ir_q[7:0]))
        else $error("low literal not taken at q2");

    flush_quiet_a: assert property ( // RULE11
        !exec |-> !DMEM_WE_O && $stable(wreg_q) && !is_jump)
        else $error("activity during jump second cycle");

    jump_flags_a: assert property ( // RULE4
        q[3] && exec && is_jump && !wr_acc |=> $stable(flags_q))
        else $error("jump changed a flag");

    inc_wreg_a: assert property ( // RULE7
        q[3] && exec && is_inc && !dest_f |=>
        wreg_q == $past(opnd_q) + 8'h01)
        else $error("increment result not in working register");

    inc_write_a: assert property ( // RULE10
        DMEM_WE_O |-> q[3] && DMEM_WDATA_O == opnd_q + 8'h01)
        else $error("file write at wrong phase or value");

    bank_addr_a: assert property ( // RULE8
        q[0] && exec && is_inc && acc_bpr |=> DMEM_ADDR_O == {bank_q, fadr})
        else $error("bank pointer address wrong");

    index_addr_a: assert property ( // RULE9
        q[0] && exec && is_inc && !acc_bpr && ext_en && fadr <= INDEX_LIMIT
        |=> DMEM_ADDR_O == $past(base_q) + {4'h0, $past(fadr)})
        else $error("indexed address wrong");

    inc_flags_a: assert property ( // RULE6
        q[3] && exec && is_inc |=>
        flags_q.z == ($past(opnd_q) == 8'hFF) &&
        flags_q.c == ($past(opnd_q) == 8'hFF) &&
        flags_q.ov == ($past(opnd_q) == 8'h7F))
        else $error("increment flags wrong");

    inc_sign_a: assert property ( // RULE6
        q[3] && exec && is_inc |=>
        flags_q.n == ($past(opnd_q) + 8'h01 >= 8'h80) &&
        flags_q.dc == ($past(opnd_q[3:0]) == 4'hF))
        else $error("increment sign or digit carry wrong");

    access_addr_a: assert property ( // RULE8
        q[0] && exec && is_inc && !acc_bpr &&
        !(ext_en && fadr <= INDEX_LIMIT) |=>
        DMEM_ADDR_O[7:0] == fadr && DMEM_ADDR_O[DADDR_W-1:8] ==
        (fadr < ACC_SPLIT ? ACC_LO_PAGE : ACC_HI_PAGE))
        else $error("access bank address wrong");

    phase_step_a: assert property ( // RULE10
        PHASE_O[0] |=> PHASE_O[1] || PHASE_O == 4'h0)
        else $error("phase did not advance from q1 to q2");

    flush_fetch_a: assert property ( // RULE11
        q[3] && !exec |=> exec && ir_q == $past(PROG_DATA_I))
        else $error("jump second cycle did not fetch the target");

    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus ack longer than one cycle");

    wb_answer_a: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered in one cycle");

endmodule

// >>> hdl/jie_inc_alu.sv
// Registered byte incrementer with arithmetic flags
`timescale 1ns/100ps
module jie_inc_alu
    import jie_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    input wire logic [7:0] val_i,
    output logic [7:0] res_o,
    output jie_flags_type flags_o
);

    logic [7:0] res_q;
    logic [7:0] res_d;
    jie_flags_type flags_q;
    jie_flags_type flags_d;

    always_comb begin
        res_d = res_q;
        flags_d = flags_q;
        if (en_i) begin
            res_d = val_i + 8'h01;
            flags_d.c = (val_i == 8'hFF);
            flags_d.dc = (val_i[3:0] == 4'hF);
            flags_d.ov = (val_i == 8'h7F);
            flags_d.n = res_d[7];
            flags_d.z = (res_d == 8'h00);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_q <= 8'h00;
            flags_q <= FLAGS_RST;
        end else begin
            res_q <= res_d;
            flags_q <= flags_d;
        end
    end

    assign res_o = res_q;
    assign flags_o = flags_q;

endmodule

// >>> hdl/jie_phase_gen.sv
// Four phase one-hot sequencer for the instruction cycle
`timescale 1ns/100ps
module jie_phase_gen (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    output logic [3:0] q_o
);

    logic [3:0] q_q;
    logic [3:0] q_d;

    always_comb begin
        q_d = q_q;
        if (en_i) begin
            q_d = {q_q[2:0], q_q[3]};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q_q <= 4'h1;
        end else begin
            q_q <= q_d;
        end
    end

    // One-cycle enable per phase, only while running
    assign q_o = q_q & {4{en_i}};

endmodule

// >>> hdl/jie_pkg.sv
// Shared constants and types for the jump and increment execute block
package jie_pkg;

    // ************************************************************
    // Core widths and opcodes
    // ************************************************************
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam logic [7:0] JUMP_OP_HI = 8'hEF;
    localparam logic [3:0] JUMP_W2_PREFIX = 4'hF;
    localparam logic [5:0] INC_OP_TOP = 6'h0A;
    localparam int INC_TOP_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int ACC_BIT = 8;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam logic [PC_W-1:0] PC_RST = 21'h00_0000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;

    // ************************************************************
    // Data memory mapping
    // ************************************************************
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [3:0] ACC_LO_PAGE = 4'h0;
    localparam logic [3:0] ACC_HI_PAGE = 4'hF;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] BANK_OFS = 8'h04;
    localparam logic [7:0] WREG_OFS = 8'h08;
    localparam logic [7:0] FLAGS_OFS = 8'h0C;
    localparam logic [7:0] PC_OFS = 8'h10;
    localparam logic [7:0] BASE_OFS = 8'h14;
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [DADDR_W-1:0] BASE_RST = 12'h000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } jie_flags_type;

    localparam jie_flags_type FLAGS_RST = 5'h00;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_FLUSH = 2'b10
    } jie_state_type;

endpackage

// >>> verif/tb_jump_and_increment_exec.sv
// Self-checking bench for the jump and increment execute block
`timescale 1ns/100ps
module tb_jump_and_increment_exec
    import jie_pkg::*;
;
    // ****************************************
    // Stimulus signals and device
    // ****************************************
    logic clk, arst_n, cyc, stb, we, ack, dwe, evt;
    logic [7:0] adr, drd, dwd;
    logic [3:0] sel, ph;
    logic [31:0] wdat, rdat;
    logic [PC_W-1:0] paddr;
    logic [15:0] pdata;
    logic [DADDR_W-1:0] daddr;
    logic [15:0] rom [int];
    logic [7:0] dmem [0:4095];
    int failures, checks;

    jie_core dut (.CLK_I(clk), .ARST_N_I(arst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PROG_ADDR_O(paddr), .PROG_DATA_I(pdata), .DMEM_ADDR_O(daddr),
        .DMEM_RDATA_I(drd), .DMEM_WDATA_O(dwd), .DMEM_WE_O(dwe),
        .PHASE_O(ph));

    function automatic logic [15:0] rom_rd(input logic [20:0] a);
        return rom.exists(a) ? rom[a] : NOP_WORD;
    endfunction

    always @(paddr or evt) pdata = rom_rd(paddr);
    assign drd = dmem[daddr];

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************
    // Bus, compare and closing tasks
    // ****************************************
    task automatic fail(input string m);
        failures++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask

    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) fail($sformatf("reg got %h exp %h", g, e));
    endtask

    task automatic cmp_port(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) fail($sformatf("port got %h exp %h", g, e));
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        if (ack !== 1'b0) fail("ack high before request");
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= wd;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wait_ph(input logic [3:0] p);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ph !== p && n < 40);
        if (ph !== p) fail("phase wait");
    endtask

    task automatic wrap_up();
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Chained segments of increments, each ending in a far jump
    task automatic gen_prog();
        logic [20:0] p, t;
        rom.delete();
        p = '0;
        for (int s = 0; s < 6; s++) begin
            for (int i = 0; i < 8; i++) begin
                rom[p] = {INC_OP_TOP, 10'($urandom)};
                p += PC_STEP;
            end
            t = (s == 5) ? '0 : {20'($urandom), 1'b0};
            rom[p] = {JUMP_OP_HI, t[8:1]};
            rom[p + 2] = {JUMP_W2_PREFIX, t[20:9]};
            rom[p + 4] = {INC_OP_TOP, 2'b11, 8'($urandom)};
            p = t;
        end
        for (int i = 0; i < 4096; i++) begin
            case ($urandom_range(3))
                0: dmem[i] = 8'hFF;
                1: dmem[i] = 8'h7F;
                2: dmem[i] = 8'h0F;
                default: dmem[i] = 8'($urandom);
            endcase
        end
        evt = ~evt;
    endtask

    // ****************************************
    // Reference model run
    // ****************************************
    task automatic run_prog(input logic ext);
        logic [31:0] d;
        logic [15:0] ir, w2;
        logic [20:0] pc;
        logic [11:0] a, base;
        logic [7:0] v, r, w, f;
        logic [3:0] bank;
        jie_flags_type fl;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        wb(1'b1, PC_OFS, 32'h0000_1234, d);
        wb(1'b0, PC_OFS, 32'h0000_0000, d);
        cmp_reg(d, 32'h0000_0000);
        wb(1'b0, 8'h18, 32'h0000_0000, d);
        cmp_reg(d, 32'h0000_0000);
        gen_prog();
        bank = 4'($urandom);
        base = 12'($urandom);
        w = 8'($urandom);
        wb(1'b1, BANK_OFS, 32'(bank), d);
        wb(1'b1, BASE_OFS, 32'(base), d);
        wb(1'b1, WREG_OFS, 32'(w), d);
        wb(1'b1, CTRL_OFS, {30'h0000_0000, 1'b1, ext}, d);
        pc = PC_RST;
        ir = NOP_WORD;
        fl = FLAGS_RST;
        for (int k = 0; k < 90; k++) begin
            wait_ph(4'b0001);
            if (k % 2 == 1) begin
                wb(1'b0, WREG_OFS, 32'h0000_0000, d);
                cmp_reg(d, 32'(w));
            end else begin
                wb(1'b0, FLAGS_OFS, 32'h0000_0000, d);
                cmp_reg(d, 32'(fl));
            end
            wait_ph(4'b1000);
            cmp_port(32'(paddr), 32'(pc));
            if (ir[15:8] == JUMP_OP_HI) begin
                w2 = rom_rd(pc);
                cmp_port(32'(dwe), 32'h0000_0000);
                pc = {w2[11:0], ir[7:0], 1'b0};
                ir = NOP_WORD;
            end else begin
                if (ir[15:INC_TOP_LSB] == INC_OP_TOP) begin
                    f = ir[7:0];
                    if (ir[ACC_BIT]) a = {bank, f};
                    else if (ext && f <= INDEX_LIMIT) a = base + 12'(f);
                    else a = {(f < ACC_SPLIT) ? ACC_LO_PAGE : ACC_HI_PAGE, f};
                    v = dmem[a];
                    r = v + 8'h01;
                    fl = '{n: r[7], ov: v == 8'h7F, z: r == 8'h00,
                           dc: v[3:0] == 4'hF, c: v == 8'hFF};
                    cmp_port(32'(daddr), 32'(a));
                    cmp_port(32'(dwe), 32'(ir[DEST_BIT]));
                    if (ir[DEST_BIT]) begin
                        cmp_port(32'(dwd), 32'(r));
                        dmem[a] = r;
                    end else begin
                        w = r;
                    end
                end else begin
                    cmp_port(32'(dwe), 32'h0000_0000);
                end
                ir = rom_rd(pc);
                pc += PC_STEP;
            end
        end
    endtask

    initial begin
        arst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0000_0000;
        evt = 1'b0;
        failures = 0;
        checks = 0;
        void'($urandom(32'h0000_E403));
        run_prog(1'b0);
        run_prog(1'b1);
        wrap_up();
    end

    initial begin
        #200us;
        failures++;
        wrap_up();
    end
endmodule
